// >>> verilog/pfh_frontplane.sv
`timescale 1ns/1ps
`include "pfh_map.svh"
// What this block does
// - send drivers on: output mode or strap, enabled
// - send data inverted from host word
// - received data inverted toward host
// - pin five: direction or control five, selectable
// - pin four: last indication or control four
// - direction high for output, low for input
// - last indication low marks final transfer
// - last source: undriven, channel, or counter zero
// - last stays low between transfers, low after reset
// - direct-write final word: counter zero only
// - control output high when bit written zero
// - attention falling edge logs event, interrupts
// - termination selected asks channel to end
// - termination stops handshake, output now, input after
// - status inputs read raw, inverted, sampled live
// - output machine: idle, control, shift, wait
// - input machine: idle, control, setup, shift, wait
// - last asserted when final output word valid
// - data valid and flag seen gives shift-out
// - control output rises three clocks after shift-out
// - flag synchronised without filter, no stretch
module pfh_frontplane
  import pfh_pkg::*;
#(
  parameter int DATA_W = 16,
  parameter int CTL_N = 6,
  parameter int CNT_W = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // host channel word source
  input wire logic [DATA_W-1:0] chan_word_i,
  input wire logic chan_word_valid_i,
  input wire logic channel_last_word_flag_i,
  output logic chan_word_ready_o,
  output logic chan_term_req_o,
  output logic attention_irq_o,
  // frontplane pins
  input wire logic [DATA_W-1:0] recv_data_i,
  input wire logic peripheral_flag_in_i,
  input wire logic peripheral_termination_in_i,
  input wire logic attention_request_in_i,
  input wire logic [CTL_N-1:0] status_inputs_i,
  input wire logic drive_strap_i,
  output logic [DATA_W-1:0] send_data_bus_o,
  output logic send_data_oe_o,
  output logic handshake_control_out_o,
  output logic pin_five_o,
  output logic pin_four_o,
  output logic pin_four_oe_o,
  output logic [CTL_N-3:0] general_control_outputs_o
);

  initial begin
    if (DATA_W < 1 || DATA_W > 32 || CTL_N != 6 || CNT_W < 1 || CNT_W > 32) begin
      $error("pfh_frontplane: unsupported parameter values");
    end
  end

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  localparam int SYN_W = DATA_W + CTL_N + 3;
  logic [SYN_W-1:0] sync1_r;
  logic [SYN_W-1:0] sync2_r;
  logic [DATA_W-1:0] rd_s;
  logic [CTL_N-1:0] sts_s;
  logic flag_s;
  logic term_s;
  logic strap_s;
  logic term_d_r;
  logic attention_request_in_d_r;

  always_ff @(posedge clk_i) begin
    sync1_r <= {recv_data_i, status_inputs_i, peripheral_flag_in_i, peripheral_termination_in_i, drive_strap_i};
    sync2_r <= sync1_r;
  end

  assign {rd_s, sts_s, flag_s, term_s, strap_s} = sync2_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_d_r <= 1'b1;
      attention_request_in_d_r <= 1'b1;
    end else begin
      term_d_r <= term_s;
      attention_request_in_d_r <= sts_s[5];
    end
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [CTL_N-1:0] ctl_r;
  logic [`PFH_C2_WIDTH-1:0] ctl2_r;
  logic [CNT_W-1:0] count_r;
  logic [DATA_W-1:0] out_word_r;
  logic out_valid_r;
  logic out_last_r;
  logic [DATA_W-1:0] in_word_r;
  logic in_full_r;
  logic attention_request_in_event_r;
  logic term_seen_r;
  logic last_low_r;
  logic handshake_control_out_r;
  logic wr_en;
  logic rd_en;
  logic sel_ok;
  logic attention_request_in_fall;
  logic term_fall;
  logic term_active;
  logic shift_out;
  logic shift_in;
  logic out_start;
  logic in_start;
  pfh_out_state_t out_state_r;
  pfh_in_state_t in_state_r;

  wire fp_en = ctl2_r[`PFH_C2_FP_ENABLE];
  wire dir_out = ctl2_r[`PFH_C2_DIR_OUT];
  wire use_cnt = ctl2_r[`PFH_C2_COUNT_USE];
  wire term_sel = ctl2_r[`PFH_C2_TERM_SELECT];

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
    hit = (adr[7:2] == ofs[7:2]);
  endfunction

  assign sel_ok = (wb_sel_i == 4'hF);
  assign wr_en = wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && sel_ok;
  assign rd_en = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i;
  assign attention_request_in_fall = ctl2_r[`PFH_C2_ATTENTION_REQUEST_IN_ENABLE] && attention_request_in_d_r && !sts_s[5];
  assign term_fall = term_d_r && !term_s;
  // a stuck-low termination keeps the handshake halted until software clears it
  assign term_active = term_sel && (term_seen_r || term_fall);

  // ---------------------------------------------------------------
  // wishbone slave: one wait cycle, then ack
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (rd_en) begin
      wb_dat_o <= 32'h0000_0000;
      if (hit(wb_adr_i, `PFH_OFS_CONTROL)) begin
        wb_dat_o[CTL_N-1:0] <= ctl_r;
      end else if (hit(wb_adr_i, `PFH_OFS_CONTROL2)) begin
        wb_dat_o[`PFH_C2_WIDTH-1:0] <= ctl2_r;
      end else if (hit(wb_adr_i, `PFH_OFS_STATUS)) begin
        wb_dat_o[CTL_N-1:0] <= ~sts_s;
        wb_dat_o[`PFH_ST_ATTENTION_REQUEST_IN_EVENT] <= attention_request_in_event_r;
        wb_dat_o[`PFH_ST_TERM_SEEN] <= term_seen_r;
        wb_dat_o[`PFH_ST_OUT_FULL] <= out_valid_r;
        wb_dat_o[`PFH_ST_IN_FULL] <= in_full_r;
        wb_dat_o[`PFH_ST_LAST] <= last_low_r;
        wb_dat_o[`PFH_ST_BUSY] <= (out_state_r != PFH_OUT_IDLE) || (in_state_r != PFH_IN_IDLE);
      end else if (hit(wb_adr_i, `PFH_OFS_COUNT)) begin
        wb_dat_o[CNT_W-1:0] <= count_r;
      end else if (hit(wb_adr_i, `PFH_OFS_DATA_IN)) begin
        wb_dat_o[DATA_W-1:0] <= in_word_r;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctl_r <= `PFH_RST_CONTROL;
      ctl2_r <= `PFH_RST_CONTROL2;
    end else if (wr_en) begin
      if (hit(wb_adr_i, `PFH_OFS_CONTROL)) begin
        ctl_r <= wb_dat_i[CTL_N-1:0];
      end
      if (hit(wb_adr_i, `PFH_OFS_CONTROL2)) begin
        ctl2_r <= wb_dat_i[`PFH_C2_WIDTH-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // attention and termination flags
  // ---------------------------------------------------------------
  wire st_clr = wr_en && hit(wb_adr_i, `PFH_OFS_STATUS);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attention_request_in_event_r <= 1'b0;
    end else if (attention_request_in_fall) begin
      attention_request_in_event_r <= 1'b1;
    end else if (st_clr && wb_dat_i[`PFH_ST_ATTENTION_REQUEST_IN_EVENT]) begin
      attention_request_in_event_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      attention_irq_o <= 1'b0;
    end else begin
      attention_irq_o <= (attention_request_in_event_r || attention_request_in_fall) && ctl2_r[`PFH_C2_IRQ_ENABLE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      term_seen_r <= 1'b0;
    end else if (term_sel && term_fall) begin
      term_seen_r <= 1'b1;
    end else if (st_clr && wb_dat_i[`PFH_ST_TERM_SEEN]) begin
      term_seen_r <= 1'b0;
    end
  end

  // asks the channel to finish: one-cycle pulse on a selected termination falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_term_req_o <= 1'b0;
    end else begin
      chan_term_req_o <= term_sel && term_fall;
    end
  end

  // ---------------------------------------------------------------
  // output word holding stage
  // ---------------------------------------------------------------
  wire bus_out_wr = wr_en && hit(wb_adr_i, `PFH_OFS_DATA_OUT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      chan_word_ready_o <= 1'b0;
    end else begin
      chan_word_ready_o <= !out_valid_r && !bus_out_wr && !chan_word_ready_o;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_valid_r <= 1'b0;
      out_last_r <= 1'b0;
      out_word_r <= '0;
    end else if (shift_out) begin
      out_valid_r <= 1'b0;
    end else if (!out_valid_r && bus_out_wr) begin
      out_valid_r <= 1'b1;
      out_word_r <= wb_dat_i[DATA_W-1:0];
      out_last_r <= 1'b0;
    end else if (!out_valid_r && chan_word_ready_o && chan_word_valid_i) begin
      out_valid_r <= 1'b1;
      out_word_r <= chan_word_i;
      out_last_r <= channel_last_word_flag_i;
    end
  end

  // ---------------------------------------------------------------
  // output handshake machine
  // ---------------------------------------------------------------
  assign out_start = (out_state_r == PFH_OUT_IDLE) && dir_out && fp_en && out_valid_r && !term_active;
  assign shift_out = (out_state_r == PFH_OUT_CONTROL) && flag_s && !term_active;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_state_r <= PFH_OUT_IDLE;
    end else begin
      unique case (out_state_r)
        PFH_OUT_IDLE: begin
          if (out_start) begin
            out_state_r <= PFH_OUT_CONTROL;
          end
        end
        PFH_OUT_CONTROL: begin
          if (term_active) begin
            out_state_r <= PFH_OUT_IDLE;
          end else if (flag_s) begin
            out_state_r <= PFH_OUT_SHIFT;
          end
        end
        PFH_OUT_SHIFT: begin
          out_state_r <= PFH_OUT_WAIT;
        end
        PFH_OUT_WAIT: begin
          if (!flag_s) begin
            out_state_r <= PFH_OUT_IDLE;
          end
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // input handshake machine
  // ---------------------------------------------------------------
  wire in_read = rd_en && hit(wb_adr_i, `PFH_OFS_DATA_IN);

  assign in_start = (in_state_r == PFH_IN_IDLE) && !dir_out && fp_en && !in_full_r && !term_active;
  assign shift_in = (in_state_r == PFH_IN_SHIFT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_state_r <= PFH_IN_IDLE;
    end else begin
      unique case (in_state_r)
        PFH_IN_IDLE: begin
          if (in_start) begin
            in_state_r <= PFH_IN_CONTROL;
          end
        end
        PFH_IN_CONTROL: begin
          // leaving input mode must not let an output-side flag shift a stale word in
          if (dir_out || !fp_en) begin
            in_state_r <= PFH_IN_IDLE;
          end else if (flag_s) begin
            in_state_r <= PFH_IN_SETUP;
          end
        end
        PFH_IN_SETUP: begin
          in_state_r <= PFH_IN_SHIFT;
        end
        PFH_IN_SHIFT: begin
          in_state_r <= PFH_IN_WAIT;
        end
        PFH_IN_WAIT: begin
          // termination is not checked here; it only blocks the next start from idle
          if (!flag_s) begin
            in_state_r <= PFH_IN_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_full_r <= 1'b0;
      in_word_r <= '0;
    end else if (shift_in) begin
      in_full_r <= 1'b1;
      in_word_r <= ~rd_s;
    end else if (in_read) begin
      in_full_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // handshake control output, no stretch
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      handshake_control_out_r <= 1'b0;
    end else if (out_state_r == PFH_OUT_SHIFT || shift_in) begin
      handshake_control_out_r <= 1'b1;
    end else if ((out_state_r == PFH_OUT_WAIT || in_state_r == PFH_IN_WAIT) && !flag_s) begin
      handshake_control_out_r <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // transfer counter and last indication
  // ---------------------------------------------------------------
  wire cnt_load = wr_en && hit(wb_adr_i, `PFH_OFS_COUNT);
  wire cnt_step = use_cnt && (out_start || in_start) && (count_r != '0);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      count_r <= '0;
    end else if (cnt_load) begin
      count_r <= wb_dat_i[CNT_W-1:0];
    end else if (cnt_step) begin
      count_r <= count_r - 1'b1;
    end
  end

  // low level persists from the end of one transfer to the first handshake of the next
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      last_low_r <= 1'b1;
    end else if (use_cnt) begin
      if (count_r == '0 && !handshake_control_out_r) begin
        last_low_r <= 1'b1;
      end else if (handshake_control_out_r && count_r != '0) begin
        last_low_r <= 1'b0;
      end
    end else if (dir_out) begin
      if (out_valid_r && out_last_r) begin
        last_low_r <= 1'b1;
      end else if (handshake_control_out_r && !out_last_r) begin
        last_low_r <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // registered pin drive
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      send_data_oe_o <= 1'b0;
      send_data_bus_o <= '0;
      handshake_control_out_o <= 1'b0;
      pin_five_o <= 1'b0;
      pin_four_o <= 1'b0;
      pin_four_oe_o <= 1'b1;
      general_control_outputs_o <= '0;
    end else begin
      send_data_oe_o <= fp_en && (dir_out || !strap_s);
      send_data_bus_o <= ~out_word_r;
      handshake_control_out_o <= handshake_control_out_r;
      general_control_outputs_o <= ~ctl_r[CTL_N-3:0];
      if (ctl2_r[`PFH_C2_PIN_SELECT]) begin
        pin_five_o <= ~ctl_r[5];
        pin_four_o <= ~ctl_r[4];
        pin_four_oe_o <= 1'b1;
      end else begin
        pin_five_o <= dir_out;
        pin_four_o <= !last_low_r;
        pin_four_oe_o <= use_cnt || dir_out;
      end
    end
  end

endmodule

// >>> verilog/pfh_map.svh
`ifndef PFH_MAP_SVH
`define PFH_MAP_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define PFH_OFS_CONTROL 8'h00
`define PFH_OFS_CONTROL2 8'h04
`define PFH_OFS_STATUS 8'h08
`define PFH_OFS_COUNT 8'h0C
`define PFH_OFS_DATA_OUT 8'h10
`define PFH_OFS_DATA_IN 8'h14
// ---------------------------------------------------------------
// control2 field positions
// ---------------------------------------------------------------
`define PFH_C2_FP_ENABLE 0
`define PFH_C2_PIN_SELECT 1
`define PFH_C2_TERM_SELECT 2
`define PFH_C2_ATTENTION_REQUEST_IN_ENABLE 3
`define PFH_C2_IRQ_ENABLE 4
`define PFH_C2_DIR_OUT 5
`define PFH_C2_COUNT_USE 6
`define PFH_C2_WIDTH 7
// ---------------------------------------------------------------
// status field positions
// ---------------------------------------------------------------
`define PFH_ST_ATTENTION_REQUEST_IN_EVENT 8
`define PFH_ST_TERM_SEEN 9
`define PFH_ST_OUT_FULL 10
`define PFH_ST_IN_FULL 11
`define PFH_ST_LAST 12
`define PFH_ST_BUSY 13
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define PFH_RST_CONTROL 6'h3F
`define PFH_RST_CONTROL2 7'h00
`endif

// >>> verilog/pfh_pkg.sv
package pfh_pkg;
  typedef enum logic [1:0] {
    PFH_OUT_IDLE,
    PFH_OUT_CONTROL,
    PFH_OUT_SHIFT,
    PFH_OUT_WAIT
  } pfh_out_state_t;
  typedef enum logic [2:0] {
    PFH_IN_IDLE,
    PFH_IN_CONTROL,
    PFH_IN_SETUP,
    PFH_IN_SHIFT,
    PFH_IN_WAIT
  } pfh_in_state_t;
endpackage

// >>> tb/pfh_frontplane_checker.sv
`timescale 1ns/1ps
module pfh_frontplane_checker #(
  parameter int DATA_W = 16,
  parameter int CTL_N = 6
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic peripheral_flag_in_i,
  input wire logic handshake_control_out_o,
  input wire logic [DATA_W-1:0] send_data_bus_o,
  input wire logic send_data_oe_o,
  input wire logic pin_five_o,
  input wire logic pin_four_o,
  input wire logic [CTL_N-3:0] general_control_outputs_o,
  input wire logic chan_term_req_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // bus and handshake relations
  // ----------------------------------------
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  a_ack: assert property (p_ack) else $error("bus request not acked");
  property p_ack_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_reset;
    $fell(rst_i) |-> !handshake_control_out_o && !send_data_oe_o && !pin_four_o && !pin_five_o;
  endproperty
  a_reset: assert property (p_reset) else $error("bad pin state after reset");
  property p_ctl_change;
    $changed(general_control_outputs_o) |-> $past(wb_ack_o && wb_we_i) || $past(wb_ack_o && wb_we_i, 2);
  endproperty
  a_ctl_change: assert property (p_ctl_change) else $error("control outputs moved without write");
  // two sync flops plus state and pin stages sit between flag and control
  property p_handshake_control_out_rise; $rose(handshake_control_out_o) |-> $past(peripheral_flag_in_i, 3); endproperty
  a_handshake_control_out_rise: assert property (p_handshake_control_out_rise) else $error("control rose without flag");
  property p_handshake_control_out_fall; $fell(handshake_control_out_o) |-> !$past(peripheral_flag_in_i, 2); endproperty
  a_handshake_control_out_fall: assert property (p_handshake_control_out_fall) else $error("control fell with flag high");
  property p_handshake_control_out_hold; handshake_control_out_o && peripheral_flag_in_i |=> handshake_control_out_o; endproperty
  a_handshake_control_out_hold: assert property (p_handshake_control_out_hold) else $error("control dropped early");
  property p_data;
    handshake_control_out_o && $past(handshake_control_out_o) |-> $stable(send_data_bus_o);
  endproperty
  a_data: assert property (p_data) else $error("send data moved during handshake");
  property p_term; chan_term_req_o |=> !chan_term_req_o; endproperty
  a_term: assert property (p_term) else $error("termination request not a pulse");
endmodule
bind pfh_frontplane pfh_frontplane_checker #(.DATA_W(DATA_W), .CTL_N(CTL_N)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
  .wb_ack_o(wb_ack_o), .peripheral_flag_in_i(peripheral_flag_in_i),
  .handshake_control_out_o(handshake_control_out_o), .send_data_bus_o(send_data_bus_o),
  .send_data_oe_o(send_data_oe_o), .pin_five_o(pin_five_o), .pin_four_o(pin_four_o),
  .general_control_outputs_o(general_control_outputs_o), .chan_term_req_o(chan_term_req_o));

// >>> tb/pfh_periph_model.sv
`timescale 1ns/1ps
module pfh_periph_model (
  input wire logic clk_i,
  input wire logic hold_i,
  input wire logic [7:0] delay_i,
  input wire logic handshake_control_out_i,
  input wire logic [15:0] word_i,
  output logic peripheral_flag_in_o,
  output logic [15:0] recv_data_o
);
  int n;
  initial begin
    peripheral_flag_in_o = 1'b0;
    recv_data_o = 16'h0000;
    forever begin
      @(posedge clk_i);
      if (!hold_i && handshake_control_out_i === 1'b0) begin
        repeat (delay_i) @(posedge clk_i);
        recv_data_o <= word_i;
        peripheral_flag_in_o <= 1'b1;
        n = 0;
        // a hold while waiting withdraws the flag, so a parked peer cannot start a transfer
        while (handshake_control_out_i !== 1'b1 && !hold_i && n < 300) begin
          @(posedge clk_i);
          n++;
        end
        repeat (delay_i) @(posedge clk_i);
        peripheral_flag_in_o <= 1'b0;
        // released bus shows the inverse so stale data cannot pass
        recv_data_o <= ~word_i;
        n = 0;
        while (handshake_control_out_i !== 1'b0 && n < 300) begin
          @(posedge clk_i);
          n++;
        end
      end
    end
  end
endmodule

// >>> tb/pfh_frontplane_tb_top.sv
`timescale 1ns/1ps
`include "pfh_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end
module pfh_frontplane_tb_top;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, flag, hold = 1, strap = 1, term = 1;
  logic [7:0] adr = 8'h00, dly = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0000_0000, q, v, ack_dat;
  logic [15:0] word = 16'h0000, recv, sd;
  logic [5:0] sts = 6'h00;
  logic [3:0] gco;
  logic ack, oe, handshake_control_out, p5, p4, p4oe, treq, irq;
  int errors = 0, comparisons = 0, tseen = 0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) if (treq === 1'b1) tseen++;
  pfh_frontplane dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wd), .wb_dat_o(ack_dat), .wb_ack_o(ack),
    .chan_word_i(16'h0000), .chan_word_valid_i(1'b0), .channel_last_word_flag_i(1'b0),
    .chan_word_ready_o(), .chan_term_req_o(treq), .attention_irq_o(irq), .recv_data_i(recv),
    .peripheral_flag_in_i(flag), .peripheral_termination_in_i(term), .attention_request_in_i(sts[5]),
    .status_inputs_i(sts), .drive_strap_i(strap), .send_data_bus_o(sd), .send_data_oe_o(oe),
    .handshake_control_out_o(handshake_control_out), .pin_five_o(p5), .pin_four_o(p4), .pin_four_oe_o(p4oe),
    .general_control_outputs_o(gco));
  pfh_periph_model peer (.clk_i(clk_i), .hold_i(hold), .delay_i(dly), .handshake_control_out_i(handshake_control_out),
    .word_i(word), .peripheral_flag_in_o(flag), .recv_data_o(recv));
  // ----------------------------------------
  // bus and wait helpers
  // ----------------------------------------
  task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d, input logic [3:0] s);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wd <= d; sel <= s;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) begin
      errors++;
      $display("CHECK FAILED bus_ack expected 1 seen %b", ack);
    end
    q = ack_dat;
    cyc <= 1'b0; stb <= 1'b0;
    @(posedge clk_i);
    @(negedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(a, 1'b1, d, 4'hF);
  endtask
  task automatic wait_handshake_control_out(input logic lvl);
    int n;
    n = 0;
    while (handshake_control_out !== lvl && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    @(negedge clk_i);
    `CHK("handshake_control_out", lvl, handshake_control_out)
  endtask
  task automatic done(input string t);
    $display("test %s finished, errors so far %0d", t, errors);
  endtask
  task automatic close_out();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #400000;
    errors++;
    close_out();
  end
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'hd4c68b94));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    `CHK("oe", 1'b0, oe)
    `CHK("last", 1'b0, p4)
    `CHK("dir", 1'b0, p5)
    `CHK("ctl", 4'h0, gco)
    bus(`PFH_OFS_CONTROL, 1'b0, 0, 4'hF);
    `CHK("control", 32'h0000_003F, q)
    bus(`PFH_OFS_CONTROL2, 1'b0, 0, 4'hF);
    `CHK("control2", 32'h0000_0000, q)
    wr(`PFH_OFS_CONTROL2, 32'h0000_0002);
    for (int i = 0; i < 5; i++) begin
      v = (i == 0) ? 32'h0000_0000 : (i == 1) ? 32'h0000_003F : $urandom & 32'h0000_003F;
      wr(`PFH_OFS_CONTROL, v);
      `CHK("ctl", ~v[3:0], gco)
      `CHK("general_control_five", ~v[5], p5)
      `CHK("general_control_four", ~v[4], p4)
    end
    bus(`PFH_OFS_CONTROL, 1'b1, ~v, 4'h1);
    bus(`PFH_OFS_CONTROL, 1'b0, 0, 4'hF);
    `CHK("partial", v, q)
    bus(8'h3C, 1'b0, 0, 4'hF);
    `CHK("unmapped", 32'h0000_0000, q)
    done("control");
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      sts <= v[5:0];
      repeat (4) @(posedge clk_i);
      bus(`PFH_OFS_STATUS, 1'b0, 0, 4'hF);
      `CHK("status", ~v[5:0], q[5:0])
    end
    done("status");
    for (int i = 0; i < 2; i++) begin
      wr(`PFH_OFS_CONTROL2, i ? 32'h0000_0008 : 32'h0000_0018);
      sts[5] <= 1'b1;
      repeat (5) @(posedge clk_i);
      sts[5] <= 1'b0;
      repeat (8) @(posedge clk_i);
      bus(`PFH_OFS_STATUS, 1'b0, 0, 4'hF);
      `CHK("attention_request_in_event", 1'b1, q[`PFH_ST_ATTENTION_REQUEST_IN_EVENT])
      `CHK("irq", ~i[0], irq)
      wr(`PFH_OFS_STATUS, 32'h0000_0100);
      `CHK("irq_clr", 1'b0, irq)
    end
    done("attention");
    wr(`PFH_OFS_CONTROL2, 32'h0000_0001);
    `CHK("oe_nostrap", 1'b0, oe)
    strap <= 1'b0;
    repeat (3) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("oe_strap", 1'b1, oe)
    strap <= 1'b1;
    done("strap");
    `CHK("dir_in", 1'b0, p5)
    `CHK("last_oe", 1'b0, p4oe)
    v = $urandom;
    word <= v[15:0];
    dly <= 8'd2;
    hold <= 1'b0;
    wait_handshake_control_out(1'b1);
    hold <= 1'b1;
    wait_handshake_control_out(1'b0);
    bus(`PFH_OFS_DATA_IN, 1'b0, 0, 4'hF);
    `CHK("data_in", ~v[15:0], q[15:0])
    done("input");
    wr(`PFH_OFS_COUNT, 32'h0000_0002);
    wr(`PFH_OFS_CONTROL2, 32'h0000_0061);
    `CHK("oe_out", 1'b1, oe)
    `CHK("dir_out", 1'b1, p5)
    hold <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      dly <= 8'($urandom % 5);
      v = $urandom;
      wr(`PFH_OFS_DATA_OUT, v);
      wait_handshake_control_out(1'b1);
      `CHK("send", ~v[15:0], sd)
      wait_handshake_control_out(1'b0);
      repeat (3) @(posedge clk_i);
      @(negedge clk_i);
      `CHK("last", (i == 1) ? 1'b0 : 1'b1, p4)
    end
    done("output");
    hold <= 1'b1;
    dly <= 8'd0;
    wr(`PFH_OFS_CONTROL2, 32'h0000_0025);
    wr(`PFH_OFS_DATA_OUT, $urandom);
    repeat (4) @(posedge clk_i);
    term <= 1'b0;
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    `CHK("term_req", 1, tseen)
    `CHK("handshake_control_out_stop", 1'b0, handshake_control_out)
    bus(`PFH_OFS_STATUS, 1'b0, 0, 4'hF);
    `CHK("term_seen", 1'b1, q[`PFH_ST_TERM_SEEN])
    done("termination");
    close_out();
  end
endmodule
